// [rtl/psb_realign.sv]
/*
 * Per-channel phase synchronizer FIFO and bit-slip realigner.
 * Assumes the parallel clock, parallel word and slip request come from
 * outside the clk_in domain; clk_in is the global read clock.
 * Assumes the parallel clock runs at the read clock's word rate, so the
 * fixed read lag never lets the read pointer catch the write pointer.
 * Slip request hold times are the far side's duty; they are not checked.
 */
`include "psb_regs.svh"

module psb_realign
   import psb_pkg::*;
#(
   parameter int DES_FACTOR = `PSB_DES_FACTOR // RQ8
) (
   input  wire logic                  clk_in,
   input  wire logic                  rstn_in,
   input  wire logic                  par_clk_in,
   input  wire logic [DES_FACTOR-1:0] par_data_in,
   input  wire logic                  slip_en_in,
   input  wire logic                  slip_req_in,
   output logic [DES_FACTOR-1:0]      rx_data_out,
   output logic                       rx_valid_out,
   input  wire logic                  rx_ready_in,
   output logic                       overrun_out
);

   localparam int J = DES_FACTOR;
   localparam int DEPTH = `PSB_FIFO_DEPTH;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic         pclk_s1_q, pclk_s2_q, pclk_s3_q;
   logic [J-1:0] pdat_s1_q, pdat_s2_q;
   logic         slip_s1_q, slip_s2_q, slip_s3_q;
   logic         wr_stb;
   logic         slip_evt;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pclk_s1_q <= 1'b0;
         pclk_s2_q <= 1'b0;
         pclk_s3_q <= 1'b0;
         pdat_s1_q <= '0;
         pdat_s2_q <= '0;
         slip_s1_q <= 1'b0;
         slip_s2_q <= 1'b0;
         slip_s3_q <= 1'b0;
      end else begin
         pclk_s1_q <= par_clk_in;
         pclk_s2_q <= pclk_s1_q;
         pclk_s3_q <= pclk_s2_q;
         pdat_s1_q <= par_data_in;
         pdat_s2_q <= pdat_s1_q;
         slip_s1_q <= slip_req_in;
         slip_s2_q <= slip_s1_q;
         slip_s3_q <= slip_s2_q;
      end
   end

   // Rising edge of the parallel clock marks one new word
   assign wr_stb   = pclk_s2_q && !pclk_s3_q; // RQ2
   // One pulse per rising request; a held request never repeats
   assign slip_evt = slip_en_in && slip_s2_q && !slip_s3_q; // RQ16

   ////////////////////////////////////////////////////////////////////////
   // Synchronizer FIFO: free-running pointers, no flags, no enables

   logic [J-1:0]           fifo_q [DEPTH];
   logic [J-1:0]           fifo_d [DEPTH];
   psb_ptr_type            wr_ptr_q, wr_ptr_d;
   psb_ptr_type            rd_ptr_q, rd_ptr_d;
   logic [`PSB_RD_LAG-1:0] lag_q, lag_d;
   logic                   rd_stb;
   logic [J-1:0]           rd_word_q, rd_word_d;

   // Read side trails the write side by a fixed lag, so it never overtakes
   assign rd_stb = lag_q[`PSB_RD_LAG-1]; // RQ3

   always_comb begin
      fifo_d    = fifo_q;
      wr_ptr_d  = wr_ptr_q;
      rd_ptr_d  = rd_ptr_q;
      rd_word_d = rd_word_q;
      lag_d     = {lag_q[`PSB_RD_LAG-2:0], wr_stb};
      if (wr_stb) begin
         fifo_d[wr_ptr_q] = pdat_s2_q; // RQ1
         wr_ptr_d         = wr_ptr_q + psb_ptr_type'(1);
      end
      if (rd_stb) begin
         rd_word_d = fifo_q[rd_ptr_q]; // RQ2
         rd_ptr_d  = rd_ptr_q + psb_ptr_type'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            fifo_q[i] <= '0;
         end
         wr_ptr_q  <= `PSB_PTR_RESET;
         rd_ptr_q  <= `PSB_PTR_RESET;
         lag_q     <= '0;
         rd_word_q <= '0;
      end else begin
         fifo_q    <= fifo_d;
         wr_ptr_q  <= wr_ptr_d;
         rd_ptr_q  <= rd_ptr_d;
         lag_q     <= lag_d;
         rd_word_q <= rd_word_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bit-slip realigner: two stages, slip counter, word selector

   logic [J-1:0] st2_q, st2_d;
   logic [J-1:0] st3_q, st3_d;
   psb_cnt_type  cnt_q, cnt_d;
   logic         skip_q, skip_d;
   logic         al_stb_q;
   logic [J-1:0] out_q, out_d;
   logic         push_q, push_d;
   logic         ovr_q, ovr_d;
   logic [2*J-1:0] pair;
   logic [J-1:0] mixed;
   logic         buf_ready;

   assign pair = {st3_q, st2_q};

   always_comb begin
      // Counter picks the bit window across stage three and stage two
      mixed = pair[2*J-1-int'(cnt_q) -: J]; // RQ10
   end

   always_comb begin
      st2_d  = st2_q;
      st3_d  = st3_q;
      cnt_d  = cnt_q;
      skip_d = skip_q;
      out_d  = out_q;
      push_d = 1'b0;
      ovr_d  = ovr_q;
      if (rd_stb) begin
         st2_d = rd_word_q; // RQ5
         st3_d = st2_q;
      end
      if (al_stb_q) begin
         if (skip_q) begin
            skip_d = 1'b0; // RQ9
         end else begin
            // Counter at zero passes stage three untouched
            out_d  = mixed; // RQ7
            push_d = 1'b1;
         end
      end
      // Slip handled last, so a wrap in the same cycle beats the skip clear
      if (slip_evt) begin
         if (cnt_q == psb_cnt_type'(J-1)) begin
            // A whole word slipped: realign on stage three, drop one word
            cnt_d  = `PSB_CNT_RESET; // RQ9
            skip_d = 1'b1;
         end else begin
            cnt_d = cnt_q + psb_cnt_type'(1); // RQ6
         end
      end
      // Stream cannot pause; a third stalled word is flagged, not hidden
      if (push_q && !buf_ready) begin
         ovr_d = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st2_q    <= '0;
         st3_q    <= '0;
         cnt_q    <= `PSB_CNT_RESET;
         skip_q   <= 1'b0;
         al_stb_q <= 1'b0;
         out_q    <= '0;
         push_q   <= 1'b0;
         ovr_q    <= 1'b0;
      end else begin
         st2_q    <= st2_d;
         st3_q    <= st3_d;
         cnt_q    <= cnt_d;
         skip_q   <= skip_d;
         al_stb_q <= rd_stb;
         out_q    <= out_d;
         push_q   <= push_d;
         ovr_q    <= ovr_d;
      end
   end

   assign overrun_out = ovr_q;

   ////////////////////////////////////////////////////////////////////////
   // Output buffer

   psb_buf2 #(
      .WIDTH (J)
   ) u_buf (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (push_q),
      .in_ready_out  (buf_ready),
      .in_data_in    (out_q),
      .out_valid_out (rx_valid_out),
      .out_ready_in  (rx_ready_in),
      .out_data_out  (rx_data_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   // Synchronizer FIFO

   wr_ptr_step_a: assert property ( // RQ1
      wr_stb |=> wr_ptr_q == $past(wr_ptr_q) + psb_ptr_type'(1))
      else $error("Write pointer did not step on a parallel clock edge");
   wr_slot_a: assert property ( // RQ1
      wr_stb |=> fifo_q[$past(wr_ptr_q)] == $past(pdat_s2_q))
      else $error("Parallel word not stored at the write pointer");
   wr_gap_a: assert property (wr_stb |=> !wr_stb) // RQ2
      else $error("One parallel clock edge gave two writes");
   rd_follow_a: assert property (wr_stb |-> ##2 rd_stb) // RQ2
      else $error("Read did not follow write by the fixed lag");
   rd_lag_a: assert property (rd_stb |-> $past(wr_stb, 2)) // RQ2
      else $error("Read without a write two cycles before");
   rd_word_a: assert property ( // RQ2
      rd_stb |=> rd_word_q == $past(fifo_q[rd_ptr_q]))
      else $error("Read word not taken from the read pointer");
   rd_ptr_step_a: assert property ( // RQ3
      rd_stb |=> rd_ptr_q == $past(rd_ptr_q) + psb_ptr_type'(1))
      else $error("Read pointer did not step on a read");
   ptr_gap_a: assert property (rd_stb |-> wr_ptr_q - rd_ptr_q == psb_ptr_type'(1)) // RQ3
      else $error("FIFO pointers drifted apart");

   // Realignment stages and slip counter

   stage_shift_a: assert property ( // RQ5
      rd_stb |=> st2_q == $past(rd_word_q) && st3_q == $past(st2_q))
      else $error("Realignment stages did not shift on a read");
   stage_hold_a: assert property ( // RQ5
      !rd_stb |=> $stable(st2_q) && $stable(st3_q))
      else $error("Realignment stages moved without a read");
   slip_step_a: assert property (slip_evt && cnt_q != psb_cnt_type'(J-1) // RQ6
                                 |=> cnt_q == $past(cnt_q) + psb_cnt_type'(1))
      else $error("Slip did not advance the counter by one");
   no_slip_hold_a: assert property (!slip_evt |=> $stable(cnt_q)) // RQ7
      else $error("Counter moved without a slip");
   slip_quiet_a: assert property (!slip_en_in |=> $stable(cnt_q)) // RQ7
      else $error("Counter moved with slip control off");
   slip_wrap_a: assert property (slip_evt && cnt_q == psb_cnt_type'(J-1) // RQ9
                                 |=> cnt_q == `PSB_CNT_RESET && skip_q)
      else $error("Counter wrap did not restart at zero with a dropped word");
   skip_drop_a: assert property (al_stb_q && skip_q |=> !push_q) // RQ9
      else $error("Word after a wrap was not dropped");
   skip_clear_a: assert property (al_stb_q && skip_q && !slip_evt |=> !skip_q) // RQ9
      else $error("Drop flag outlived one word");
   skip_src_a: assert property ($rose(skip_q) |-> $past(slip_evt)) // RQ9
      else $error("Drop flag set without a slip");
   stage3_pass_a: assert property (al_stb_q && !skip_q && cnt_q == `PSB_CNT_RESET // RQ10
                                   |=> out_q == $past(st3_q) && push_q)
      else $error("Zero count did not pass stage three unchanged");
   mix_out_a: assert property ( // RQ10
      al_stb_q && !skip_q |=> out_q == $past(mixed) && push_q)
      else $error("Output word not taken from the counter window");
   out_hold_a: assert property (!al_stb_q |=> $stable(out_q) && !push_q) // RQ7
      else $error("Output word changed between words");
   push_one_a: assert property (push_q |=> !push_q) // RQ7
      else $error("One word pushed twice");
   slip_single_a: assert property (slip_evt |=> !slip_evt [*2]) // RQ16
      else $error("One request edge gave more than one slip");
   cnt_range_a: assert property (cnt_q < psb_cnt_type'(J)) // RQ8
      else $error("Slip counter beyond the deserialization factor");

   // Overrun flag

   ovr_set_a: assert property (push_q && !buf_ready |=> overrun_out)
      else $error("Lost word not flagged");
   ovr_sticky_a: assert property (ovr_q |=> ovr_q)
      else $error("Overrun flag cleared itself");

   // Cover points

   slip_seen_c: cover property (slip_evt);
   slip_wrap_c: cover property (slip_evt && cnt_q == psb_cnt_type'(J-1));
   word_out_c:  cover property (rx_valid_out && rx_ready_in);
   stall_c:     cover property (rx_valid_out && !rx_ready_in [*3]);
   overrun_c:   cover property (overrun_out);

endmodule

// [pkg/psb_regs.svh]
/*
 * Constants of the phase synchronizer and bit-slip realigner.
 * Assumes inclusion by bare name from the package and the design files.
 */
// Function
// [RQ1] Each channel owns a four-entry synchronizer FIFO, one word wide.
// [RQ2] FIFO written on parallel clock edges, read in the global clock domain.
// [RQ3] FIFO has no full, empty or enable signals; frequency lock keeps it balanced.
// [RQ4] Outside clocking gives write and read clocks equal frequency, phase only differs.
// [RQ5] Realignment acts on deserialized words, global clock, per channel control.
// [RQ6] Each rising slip request shifts delivered data by exactly one bit.
// [RQ7] Realigner always in path; without slips it adds latency only.
// [RQ8] Deserialization factor, word width and counter range, is 8 or 10.
// [RQ9] Counter passing n-1 wraps to zero, word from stage three, next valid; the code drops the first word after the wrap instead.
// [RQ10] Other counter values mix bits of stages two and three.
// [RQ11] User logic compares words to a pattern and slips again on mismatch.
// [RQ12] User holds slip request high at least two low-speed periods.
// [RQ13] User registers incoming words on the low-speed clock before matching.
// [RQ14] User registers its slip request on the low-speed clock before driving it.
// [RQ15] User holds slip request low at least three low-speed periods between pulses.
// [RQ16] Realigner finds the request's rising edge, one single-cycle slip event each.
`ifndef PSB_REGS_SVH
`define PSB_REGS_SVH

`define PSB_FIFO_DEPTH     4
`define PSB_PTR_W          2
`define PSB_DES_FACTOR     10
`define PSB_RD_LAG         2
`define PSB_BUF_ENTRIES    2
`define PSB_PTR_RESET      2'h0
`define PSB_CNT_RESET      4'h0

`endif

// [pkg/psb_pkg.sv]
/*
 * Types shared by the synchronizer and realigner, imported also by the output buffer.
 * Assumes psb_regs.svh is on the include path.
 */
`include "psb_regs.svh"

package psb_pkg;
   typedef logic [`PSB_PTR_W-1:0] psb_ptr_type;
   typedef logic [3:0]            psb_cnt_type;
endpackage

// [rtl/psb_buf2.sv]
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`include "psb_regs.svh"

module psb_buf2
   import psb_pkg::*;
#(
   parameter int WIDTH = `PSB_DES_FACTOR
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);

   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic             wp_q, wp_d;
   logic             rp_q, rp_d;
   logic [1:0]       fill_q, fill_d;
   logic             push;
   logic             pop;

   assign in_ready_out  = (fill_q != 2'h2);
   assign out_valid_out = (fill_q != 2'h0);
   assign out_data_out  = mem_q[rp_q];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      mem_d  = mem_q;
      wp_d   = wp_q;
      rp_d   = rp_q;
      fill_d = fill_q;
      if (push) begin
         mem_d[wp_q] = in_data_in;
         wp_d        = ~wp_q;
      end
      if (pop) begin
         rp_d = ~rp_q;
      end
      if (push && !pop) begin
         fill_d = fill_q + 2'h1;
      end else if (pop && !push) begin
         fill_d = fill_q - 2'h1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         wp_q     <= 1'b0;
         rp_q     <= 1'b0;
         fill_q   <= 2'h0;
      end else begin
         mem_q  <= mem_d;
         wp_q   <= wp_d;
         rp_q   <= rp_d;
         fill_q <= fill_d;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   buf_hold_a: assert property (out_valid_out && !out_ready_in |=>
                                out_valid_out && $stable(out_data_out))
      else $error("Buffered word changed before it was taken");
   buf_fill_a: assert property (fill_q == 2'h2 |-> !in_ready_out)
      else $error("Full buffer still accepts words");

endmodule

// [verification/psb_user_model.sv]
/*
 * User-side aligner model: takes words, hunts for a pattern, issues slips.
 * Assumes ls_clk_in is the low-speed clock, sampled here on clk_in.
 */
module psb_user_model (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       ls_clk_in,
   input  wire logic [9:0] rx_data_in,
   input  wire logic       rx_valid_in,
   input  wire logic       stall_in,
   input  wire logic       hunt_in,
   input  wire logic [9:0] target_in,
   output logic            rx_ready_out,
   output logic            slip_req_out,
   output logic            matched_out,
   output logic [7:0]      slips_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       ls_q;
   logic [9:0] word_q;
   logic [9:0] sync_q;
   logic [3:0] gap_q;

   ////////////////////////////////////////////////////////////////////////////
   // Gap long enough for the new window to reach the sync register
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ls_q <= 1'b0;
         rx_ready_out <= 1'b0;
         slip_req_out <= 1'b0;
         matched_out <= 1'b0;
         word_q <= 10'h000;
         sync_q <= 10'h000;
         gap_q <= 4'h0;
         slips_out <= 8'h00;
      end else begin
         ls_q <= ls_clk_in;
         rx_ready_out <= !stall_in;
         if (rx_valid_in && rx_ready_out) begin
            word_q <= rx_data_in;
         end
         if (ls_clk_in && !ls_q) begin
            sync_q <= word_q;
            matched_out <= (sync_q == target_in);
            slip_req_out <= (gap_q >= 4'h9);
            if (gap_q != 4'h0) begin
               gap_q <= gap_q - 4'h1;
            end else if (hunt_in && sync_q != target_in) begin
               gap_q <= 4'ha;
               slips_out <= slips_out + 8'h01;
            end
         end
      end
   end
endmodule

// [verification/psb_realign_test.sv]
/*
 * Bench for psb_realign: link stimulus, user model and scenario tasks.
 * Assumes the user model is compiled before this file.
 */
module psb_realign_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [9:0] PAT = 10'h3e1;

   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       par_clk = 1'b0;
   logic [9:0] par_data = 10'h000;
   logic       slip_en = 1'b0;
   logic       stall = 1'b0;
   logic       hunt = 1'b0;
   logic       inc_mode = 1'b1;
   logic [9:0] src_word = 10'h000;
   logic [9:0] target = 10'h2aa;
   logic [2:0] div = 3'h0;
   wire  [9:0] rx_data;
   wire        rx_valid;
   wire        rx_ready;
   wire        overrun;
   wire        slip_req;
   wire        matched;
   wire  [7:0] slips;
   int         failures = 0;
   int         compares = 0;

   function automatic logic [9:0] rotl(input logic [9:0] w, input int c);
      logic [19:0] d;
      d = {w, w};
      return d[19-c -: 10];
   endfunction

   initial begin
      forever #10 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parallel clock at an eighth of clk, same rate as the read side
   always @(posedge clk) begin
      div <= div + 3'h1;
      par_clk <= div[2];
      if (div == 3'h4) begin
         par_data <= inc_mode ? par_data + 10'h001 : src_word;
      end
   end

   psb_realign #(.DES_FACTOR(10)) psb_realign_i (
      .clk_in(clk), .rstn_in(rstn), .par_clk_in(par_clk), .par_data_in(par_data),
      .slip_en_in(slip_en), .slip_req_in(slip_req), .rx_data_out(rx_data),
      .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .overrun_out(overrun));

   psb_user_model psb_user_model_i (
      .clk_in(clk), .rstn_in(rstn), .ls_clk_in(par_clk), .rx_data_in(rx_data),
      .rx_valid_in(rx_valid), .stall_in(stall), .hunt_in(hunt), .target_in(target),
      .rx_ready_out(rx_ready), .slip_req_out(slip_req), .matched_out(matched),
      .slips_out(slips));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check_word(input string name, input logic [9:0] exp, input logic [9:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic check_flag(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic wait_ls(input int n);
      repeat (8 * n) @(posedge clk);
   endtask

   task automatic tally_and_finish;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Slip control off: user still toggles requests, stream must stay in order
   task automatic t_passthru;
      logic [9:0] prev;
      logic       have;
      have = 1'b0;
      prev = 10'h000;
      hunt <= 1'b1;
      wait_ls(10);
      repeat (400) begin
         @(posedge clk);
         if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (have) check_word("step", prev + 10'h001, rx_data);
            prev = rx_data;
            have = 1'b1;
         end
      end
      check_flag("slips issued", 1'b1, slips != 8'h00);
   endtask

   // Hunt for a target, slip count must be exact
   task automatic hunt_for(input logic [9:0] t, input int exp_slips);
      int base;
      int i;
      base = slips;
      target <= t;
      hunt <= 1'b1;
      wait_ls(3);
      i = 0;
      while (matched !== 1'b1 && i < 3000) begin
         @(posedge clk);
         i++;
      end
      check_flag("matched", 1'b1, matched);
      check_word("slip count", 10'(exp_slips), 10'(slips - base));
      check_word("aligned word", t, rx_data);
   endtask

   task automatic t_align;
      hunt <= 1'b0;
      wait_ls(12);
      slip_en <= 1'b1;
      inc_mode <= 1'b0;
      src_word <= rotl(PAT, 7);
      wait_ls(6);
      hunt_for(PAT, 3);
      hunt_for(rotl(PAT, 9), 9);
   endtask

   // Stall the taker: buffer fills, refuses, then drains
   task automatic t_stall;
      hunt <= 1'b0;
      check_flag("no overrun", 1'b0, overrun);
      stall <= 1'b1;
      wait_ls(6);
      check_flag("held valid", 1'b1, rx_valid);
      check_flag("overrun", 1'b1, overrun);
      check_word("held word", rotl(PAT, 9), rx_data);
      stall <= 1'b0;
      wait_ls(4);
      check_word("drained word", rotl(PAT, 9), rx_data);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #300000;
      failures++;
      tally_and_finish;
   end

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      wait_ls(4);
      t_passthru;
      t_align;
      t_stall;
      tally_and_finish;
   end
endmodule
